// ### tcr_router.sv
// Trigger crosspoint router: input inversion, OR crosspoint, output
// inversion and enables, behind an AXI4-Lite register slave.
// Assumes all line inputs are synchronous to SYS_CLK.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Each output stays quiet until individually enabled
// - Input never routed to same-named output
// - One input may feed many outputs
// - Unrouted output sees constant zero
// - Several routed inputs are ORed together
// - Inverting inputs and output gives AND
// - Per-line input invert for bus, radial lines
// - Per-line output invert for bus, radial lines
// - Port input inversion set in one update
// - Port output settings act only when driving
// - Inputs assigned to an output read back
// - Per-line output enable for bus, radial lines
module tcr_router (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // AXI4-Lite write address and data
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // Front-panel ports
    input wire logic [5:0] PORT_I,
    output logic [5:0] PORT_O,
    output logic [5:0] PORT_OE,
    // Shared trigger lines
    input wire logic [31:0] SHARED_TRIGGER_LINE_I,
    output logic [31:0] SHARED_TRIGGER_LINE_O,
    output logic [31:0] SHARED_TRIGGER_LINE_OE,
    // Radial trigger lines
    input wire logic [31:0] RADIAL_TRIGGER_LINE_I,
    output logic [31:0] RADIAL_TRIGGER_LINE_O,
    output logic [31:0] RADIAL_TRIGGER_LINE_OE,
    // Status flags
    input wire logic [3:0] FLAG_I
);
    // Local copies of package sizes used in the declarations below
    localparam int SEL_W = tcr_pkg::SEL_W;
    localparam int N_OUT = tcr_pkg::N_OUT;
    localparam int ROW_W = tcr_pkg::ROW_W;
    localparam logic [ROW_W-1:0] ROW_MASK = tcr_pkg::ROW_MASK;

    // ==========================================================
    // Reset synchroniser
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Release reset through two flops
    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Register and bus state
    logic [31:0] bus_in_inv_q, bus_in_inv_d, rad_in_inv_q, rad_in_inv_d;
    logic [31:0] bus_out_inv_q, bus_out_inv_d;
    logic [31:0] rad_out_inv_q, rad_out_inv_d;
    logic [31:0] bus_oe_q, bus_oe_d, rad_oe_q, rad_oe_d;
    logic [5:0] port_in_inv_q, port_in_inv_d;
    logic [5:0] port_out_inv_q, port_out_inv_d;
    logic [11:0] port_drv_q, port_drv_d;
    logic sw_shared_trigger_line_q, sw_shared_trigger_line_d;
    logic [SEL_W-1:0] sel_q, sel_d;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire, sel_ok, route_we;
    logic [ROW_W-1:0] route_q [N_OUT];
    logic [ROW_W-1:0] row_sel, row_new;
    logic [31:0] wmask;

    assign sel_ok = (sel_q < SEL_W'(N_OUT));
    assign row_sel = sel_ok ? route_q[sel_q] : '0;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Merge write data into an old value under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [31:0] msk);
        merge = (old & ~msk) | (dat & msk);
    endfunction

    // Bus handshakes, register writes and read data
    always_comb
    begin
        bus_in_inv_d = bus_in_inv_q;
        rad_in_inv_d = rad_in_inv_q;
        bus_out_inv_d = bus_out_inv_q;
        rad_out_inv_d = rad_out_inv_q;
        bus_oe_d = bus_oe_q;
        rad_oe_d = rad_oe_q;
        port_in_inv_d = port_in_inv_q;
        port_out_inv_d = port_out_inv_q;
        port_drv_d = port_drv_q;
        sw_shared_trigger_line_d = sw_shared_trigger_line_q;
        sel_d = sel_q;
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        route_we = 1'b0;
        row_new = row_sel;
        // Capture address and data independently
        if (AWVALID && awready_q)
        begin
            aw_hold_d = 1'b1;
            awaddr_d = AWADDR;
        end
        if (WVALID && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d = WDATA;
            wstrb_d = WSTRB;
        end
        if (BVALID && BREADY)
            bvalid_d = 1'b0;
        if (wr_fire)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = tcr_pkg::RESP_OKAY;
            case (awaddr_q)
                tcr_pkg::OFS_BUS_IN_INV:
                    bus_in_inv_d = merge(bus_in_inv_q, wdata_q, wmask);
                tcr_pkg::OFS_RAD_IN_INV:
                    rad_in_inv_d = merge(rad_in_inv_q, wdata_q, wmask);
                tcr_pkg::OFS_BUS_OUT_INV:
                    bus_out_inv_d = merge(bus_out_inv_q, wdata_q, wmask);
                tcr_pkg::OFS_RAD_OUT_INV:
                    rad_out_inv_d = merge(rad_out_inv_q, wdata_q, wmask);
                tcr_pkg::OFS_BUS_OE:
                    bus_oe_d = merge(bus_oe_q, wdata_q, wmask);
                tcr_pkg::OFS_RAD_OE:
                    rad_oe_d = merge(rad_oe_q, wdata_q, wmask);
                tcr_pkg::OFS_PORT_IN_CFG:
                    // All port input inversions in one write
                    port_in_inv_d = 6'(merge({26'h0, port_in_inv_q},
                                             wdata_q, wmask));
                tcr_pkg::OFS_PORT_OUT_CFG:
                begin
                    port_out_inv_d = 6'(merge({26'h0, port_out_inv_q},
                        wdata_q, wmask) >> tcr_pkg::POC_INV_LSB);
                    port_drv_d = 12'(merge({12'h0, port_drv_q, 8'h0},
                        wdata_q, wmask) >> tcr_pkg::POC_DRV_LSB);
                end
                tcr_pkg::OFS_SW_SHARED_TRIGGER_LINE:
                    sw_shared_trigger_line_d = wstrb_q[0] ? wdata_q[0] : sw_shared_trigger_line_q;
                tcr_pkg::OFS_ROUTE_SEL:
                    sel_d = wstrb_q[0] ? wdata_q[SEL_W-1:0] : sel_q;
                tcr_pkg::OFS_ROUTE_W0, tcr_pkg::OFS_ROUTE_W1,
                tcr_pkg::OFS_ROUTE_W2:
                begin
                    // Any pattern of other inputs allowed, so fan-out is free
                    route_we = sel_ok;
                    case (awaddr_q)
                        tcr_pkg::OFS_ROUTE_W0:
                            row_new[31:0] = merge(row_sel[31:0], wdata_q,
                                                  wmask);
                        tcr_pkg::OFS_ROUTE_W1:
                            row_new[63:32] = merge(row_sel[63:32], wdata_q,
                                                   wmask);
                        default:
                            row_new[95:64] = merge(row_sel[95:64], wdata_q,
                                                   wmask);
                    endcase
                    // Self connection dropped silently
                    row_new = row_new & ROW_MASK
                              & ~(ROW_W'(1) << sel_q);
                end
                default:
                    bresp_d = tcr_pkg::RESP_SLVERR;
            endcase
        end
        // Reads answer in the cycle after the address is taken
        if (RVALID && RREADY)
            rvalid_d = 1'b0;
        if (ARVALID && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = tcr_pkg::RESP_OKAY;
            case (ARADDR)
                tcr_pkg::OFS_BUS_IN_INV, tcr_pkg::OFS_RAD_IN_INV,
                tcr_pkg::OFS_BUS_OUT_INV, tcr_pkg::OFS_RAD_OUT_INV:
                    rdata_d = 32'h0000_0000;
                tcr_pkg::OFS_BUS_OE: rdata_d = bus_oe_q;
                tcr_pkg::OFS_RAD_OE: rdata_d = rad_oe_q;
                tcr_pkg::OFS_PORT_IN_CFG: rdata_d = {26'h0, port_in_inv_q};
                tcr_pkg::OFS_PORT_OUT_CFG:
                    rdata_d = {12'h0, port_drv_q, 2'h0, port_out_inv_q};
                tcr_pkg::OFS_SW_SHARED_TRIGGER_LINE: rdata_d = {31'h0, sw_shared_trigger_line_q};
                tcr_pkg::OFS_ROUTE_SEL: rdata_d = {25'h0, sel_q};
                // Inputs assigned to the selected output
                tcr_pkg::OFS_ROUTE_W0: rdata_d = row_sel[31:0];
                tcr_pkg::OFS_ROUTE_W1: rdata_d = row_sel[63:32];
                tcr_pkg::OFS_ROUTE_W2: rdata_d = row_sel[95:64];
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = tcr_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d = !w_hold_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Register the bus and configuration state
    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_in_inv_q <= tcr_pkg::RST_INV;
            rad_in_inv_q <= tcr_pkg::RST_INV;
            bus_out_inv_q <= tcr_pkg::RST_INV;
            rad_out_inv_q <= tcr_pkg::RST_INV;
            bus_oe_q <= tcr_pkg::RST_OE;
            rad_oe_q <= tcr_pkg::RST_OE;
            port_in_inv_q <= 6'h00;
            port_out_inv_q <= 6'h00;
            port_drv_q <= 12'h000;
            sw_shared_trigger_line_q <= 1'b0;
            sel_q <= 7'h00;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            bus_in_inv_q <= bus_in_inv_d;
            rad_in_inv_q <= rad_in_inv_d;
            bus_out_inv_q <= bus_out_inv_d;
            rad_out_inv_q <= rad_out_inv_d;
            bus_oe_q <= bus_oe_d;
            rad_oe_q <= rad_oe_d;
            port_in_inv_q <= port_in_inv_d;
            port_out_inv_q <= port_out_inv_d;
            port_drv_q <= port_drv_d;
            sw_shared_trigger_line_q <= sw_shared_trigger_line_d;
            sel_q <= sel_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Crosspoint rows, all empty after reset
    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int o = 0; o < N_OUT; o++)
                route_q[o] <= '0;
        end
        else if (route_we)
            route_q[sel_q] <= row_new;
    end

    // ==========================================================
    // Crosspoint datapath
    logic [ROW_W-1:0] in_vec;
    logic [N_OUT-1:0] or_res;
    logic [5:0] port_o_d, port_oe_d;
    logic [31:0] bus_o_d, rad_o_d;

    // Input inversion ahead of the switch
    assign in_vec = {21'h0, FLAG_I, sw_shared_trigger_line_q,
                     RADIAL_TRIGGER_LINE_I ^ rad_in_inv_q,
                     SHARED_TRIGGER_LINE_I ^ bus_in_inv_q,
                     PORT_I ^ port_in_inv_q};

    // OR of every routed input, zero when none
    always_comb
    begin
        for (int o = 0; o < N_OUT; o++)
            or_res[o] = |(in_vec & route_q[o]);
    end

    // Output inversion and drive gating
    always_comb
    begin
        for (int p = 0; p < 6; p++)
        begin
            // Output settings only act while driving
            case (tcr_pkg::tcr_drive_t'(port_drv_q[2*p +: 2]))
                tcr_pkg::DRV_PUSH:
                begin
                    port_o_d[p] = or_res[p] ^ port_out_inv_q[p];
                    port_oe_d[p] = 1'b1;
                end
                tcr_pkg::DRV_OPEN:
                begin
                    port_o_d[p] = 1'b0;
                    port_oe_d[p] = !(or_res[p] ^ port_out_inv_q[p]);
                end
                default:
                begin
                    port_o_d[p] = 1'b0;
                    port_oe_d[p] = 1'b0;
                end
            endcase
        end
        // Inverted OR gives AND of inverted inputs
        bus_o_d = bus_oe_q & (or_res[37:6] ^ bus_out_inv_q);
        rad_o_d = rad_oe_q & (or_res[69:38] ^ rad_out_inv_q);
    end

    // Register all line outputs
    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PORT_O <= 6'h00;
            PORT_OE <= 6'h00;
            SHARED_TRIGGER_LINE_O <= 32'h0000_0000;
            SHARED_TRIGGER_LINE_OE <= 32'h0000_0000;
            RADIAL_TRIGGER_LINE_O <= 32'h0000_0000;
            RADIAL_TRIGGER_LINE_OE <= 32'h0000_0000;
        end
        else
        begin
            PORT_O <= port_o_d;
            PORT_OE <= port_oe_d;
            SHARED_TRIGGER_LINE_O <= bus_o_d;
            SHARED_TRIGGER_LINE_OE <= bus_oe_q;
            RADIAL_TRIGGER_LINE_O <= rad_o_d;
            RADIAL_TRIGGER_LINE_OE <= rad_oe_q;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_rd_w0;
        ARVALID && arready_q && ARADDR == tcr_pkg::OFS_ROUTE_W0;
    endsequence

    a_no_self_route: assert property (sel_ok |-> !row_sel[sel_q])
        else $error("output routed to its own input");
    a_disabled_quiet: assert property (!bus_oe_q[0] |=>
        !SHARED_TRIGGER_LINE_O[0]) else $error("disabled line driven");
    a_oe_follows: assert property (##1 SHARED_TRIGGER_LINE_OE ==
        $past(bus_oe_q)) else $error("line enable mismatch");
    a_empty_zero: assert property (route_q[6] == '0 |->
        !or_res[6]) else $error("unrouted output not zero");
    a_or_high: assert property (|(in_vec & route_q[6]) |->
        or_res[6]) else $error("OR result low");
    a_and_mode: assert property (route_q[38] == ROW_W'(3)
        && port_in_inv_q[1:0] == 2'h3 && rad_out_inv_q[0] && rad_oe_q[0]
        |=> RADIAL_TRIGGER_LINE_O[0] == $past(&PORT_I[1:0]))
        else $error("AND mode wrong");
    a_in_invert: assert property (bus_in_inv_q[2] |->
        in_vec[8] == !SHARED_TRIGGER_LINE_I[2]) else $error("no invert");
    a_out_invert: assert property (bus_oe_q[0] && bus_out_inv_q[0]
        |=> SHARED_TRIGGER_LINE_O[0] == !$past(or_res[6]))
        else $error("output not inverted");
    a_port_undriven: assert property (port_drv_q[1:0] == 2'h0
        |=> !PORT_OE[0] && !PORT_O[0]) else $error("input port driven");
    a_route_read: assert property (s_rd_w0 |=> RVALID
        && RDATA == $past(row_sel[31:0])) else $error("bad route readback");
    a_fanout: assert property (route_q[6][0] && route_q[38][0]
        && PORT_I[0] != port_in_inv_q[0] |-> or_res[6] && or_res[38])
        else $error("fan-out lost");
    a_inv_reset: assert property ($rose(rst_n) |->
        bus_in_inv_q == '0 && bus_out_inv_q == '0) else $error("inv set");
endmodule

// ### tcr_pkg.sv
// Constants, register map and types for the trigger crosspoint router.
// Assumes a single 10 MHz system clock and an AXI4-Lite register bus.
package tcr_pkg;
    // ==========================================================
    // Line counts and crosspoint index layout
    localparam int N_PORT = 6;
    localparam int N_LINE = 32;
    localparam int N_FLAG = 4;
    localparam int IDX_PORT = 0;
    localparam int IDX_BUS = 6;
    localparam int IDX_RAD = 38;
    localparam int IDX_SW = 70;
    localparam int IDX_FLAG = 71;
    localparam int N_OUT = 70;
    localparam int N_IN = 75;
    localparam int ROW_W = 96;
    localparam int SEL_W = 7;
    localparam logic [ROW_W-1:0] ROW_MASK = {21'h0, {75{1'b1}}};
    // ==========================================================
    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_BUS_IN_INV = 8'h00;
    localparam logic [7:0] OFS_RAD_IN_INV = 8'h04;
    localparam logic [7:0] OFS_BUS_OUT_INV = 8'h08;
    localparam logic [7:0] OFS_RAD_OUT_INV = 8'h0C;
    localparam logic [7:0] OFS_BUS_OE = 8'h10;
    localparam logic [7:0] OFS_RAD_OE = 8'h14;
    localparam logic [7:0] OFS_PORT_IN_CFG = 8'h18;
    localparam logic [7:0] OFS_PORT_OUT_CFG = 8'h1C;
    localparam logic [7:0] OFS_SW_SHARED_TRIGGER_LINE = 8'h20;
    localparam logic [7:0] OFS_ROUTE_SEL = 8'h24;
    localparam logic [7:0] OFS_ROUTE_W0 = 8'h28;
    localparam logic [7:0] OFS_ROUTE_W1 = 8'h2C;
    localparam logic [7:0] OFS_ROUTE_W2 = 8'h30;
    // ==========================================================
    // Field positions and reset values
    localparam int POC_INV_LSB = 0;
    localparam int POC_DRV_LSB = 8;
    localparam logic [31:0] RST_INV = 32'h0000_0000;
    localparam logic [31:0] RST_OE = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Port drive kinds
    typedef enum logic [1:0] {
        DRV_INPUT = 2'h0,
        DRV_PUSH = 2'h1,
        DRV_OPEN = 2'h2
    } tcr_drive_t;
endpackage

// ### tcr_partner.sv
// Far-side model: backplane trigger lines and front-panel ports.
// Assumes the bench sets the levels that this side offers.
`timescale 1ns/1ps
// ==========================================
// Wire resolution between router and far side
module tcr_partner (
    // Levels the far side offers
    input wire logic [5:0] port_drv,
    input wire logic [31:0] shared_drv,
    input wire logic [31:0] radial_drv,
    // Router drive and enables
    input wire logic [5:0] port_o,
    input wire logic [5:0] port_oe,
    input wire logic [31:0] shared_o,
    input wire logic [31:0] shared_oe,
    input wire logic [31:0] radial_o,
    input wire logic [31:0] radial_oe,
    // Resolved wire levels
    output logic [5:0] port_w,
    output logic [31:0] shared_w,
    output logic [31:0] radial_w
);
    // Router wins where enabled, far side holds a released line
    assign port_w = (port_oe & port_o) | (~port_oe & port_drv);
    assign shared_w = (shared_oe & shared_o)
                      | (~shared_oe & shared_drv);
    assign radial_w = (radial_oe & radial_o)
                      | (~radial_oe & radial_drv);
endmodule

// ### tcr_router_bench.sv
// Self-checking bench for the trigger crosspoint router.
// Assumes the AXI4-Lite slave and the far-side model in tcr_partner.
`timescale 1ns/1ps
// ==========================================
// Stimulus, register tasks and checks
module tcr_router_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, sh_o, sh_oe, sh_w, rd_o, rd_oe, rd_w;
    logic [31:0] shared_drv = 32'h0, radial_drv = 32'h0;
    logic [5:0] port_drv = 6'h00, port_o, port_oe, port_w;
    logic [31:0] cfg_tab [4] = '{32'h1, 32'h100, 32'h101, 32'h201};
    logic [1:0] exp_tab [4] = '{2'h0, 2'h3, 2'h1, 2'h1};
    int num_errors = 0;
    int cmp_count = 0;
    int i;

    // Clock at 10 MHz
    always #50 sys_clk = ~sys_clk;

    // Router and far side
    tcr_router i_dut (.SYS_CLK(sys_clk), .RSTN(rstn),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .PORT_I(port_w), .PORT_O(port_o), .PORT_OE(port_oe),
        .SHARED_TRIGGER_LINE_I(sh_w), .SHARED_TRIGGER_LINE_O(sh_o),
        .SHARED_TRIGGER_LINE_OE(sh_oe), .RADIAL_TRIGGER_LINE_I(rd_w),
        .RADIAL_TRIGGER_LINE_O(rd_o), .RADIAL_TRIGGER_LINE_OE(rd_oe),
        .FLAG_I(4'h0));
    tcr_partner i_far (.port_drv(port_drv), .shared_drv(shared_drv),
        .radial_drv(radial_drv), .port_o(port_o), .port_oe(port_oe),
        .shared_o(sh_o), .shared_oe(sh_oe), .radial_o(rd_o),
        .radial_oe(rd_oe), .port_w(port_w), .shared_w(sh_w),
        .radial_w(rd_w));

    // Verdict and end of run
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A bus wait that used up its bound ends the run
    task automatic to_chk(input int n);
        if (n >= 40)
        begin
            num_errors++;
            $display("ERROR %0t bus answer missing", $time);
            finish_test();
        end
    endtask

    // Write one word; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge sys_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        resp = bresp;
        to_chk(n);
        @(posedge sys_clk);
    endtask

    // Read one word into rdat and resp
    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge sys_clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        rdat = rdata;
        resp = rresp;
        to_chk(n);
        @(posedge sys_clk);
    endtask

    // Let line changes pass the registered outputs
    task automatic settle;
        repeat (2) @(posedge sys_clk);
    endtask

    // Test sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        chk(sh_oe, 32'h0);
        rd(tcr_pkg::OFS_RAD_OE);
        chk(rdat, tcr_pkg::RST_OE);
        rd(8'h40);
        chk({30'h0, resp}, {30'h0, tcr_pkg::RESP_SLVERR});
        wr(8'h40, 32'hF);
        chk({30'h0, resp}, {30'h0, tcr_pkg::RESP_SLVERR});
        wr(tcr_pkg::OFS_RAD_OE, 32'h20);
        chk({30'h0, resp}, {30'h0, tcr_pkg::RESP_OKAY});
        settle();
        chk(rd_o, 32'h0);
        chk(rd_oe, 32'h20);
        $display("Test reset done");
        wr(tcr_pkg::OFS_ROUTE_SEL, 32'h6);
        wr(tcr_pkg::OFS_ROUTE_W0, 32'h41);
        wr(tcr_pkg::OFS_ROUTE_W2, 32'h40);
        rd(tcr_pkg::OFS_ROUTE_W0);
        chk(rdat, 32'h1);
        rd(tcr_pkg::OFS_ROUTE_W2);
        chk(rdat, 32'h40);
        port_drv <= 6'h01;
        settle();
        chk(sh_o, 32'h0);
        wr(tcr_pkg::OFS_BUS_OE, 32'h1);
        for (i = 0; i < 4; i++)
        begin
            port_drv <= {5'h00, i[0]};
            wr(tcr_pkg::OFS_SW_SHARED_TRIGGER_LINE, {31'h0, i[1]});
            settle();
            chk(sh_o, {31'h0, i != 0});
        end
        $display("Test routing done");
        wr(tcr_pkg::OFS_SW_SHARED_TRIGGER_LINE, 32'h0);
        wr(tcr_pkg::OFS_ROUTE_SEL, 32'h26);
        wr(tcr_pkg::OFS_ROUTE_W0, 32'h1);
        wr(tcr_pkg::OFS_RAD_OE, 32'h1);
        for (i = 1; i >= 0; i--)
        begin
            port_drv <= {5'h00, i[0]};
            settle();
            chk({30'h0, sh_o[0], rd_o[0]}, {30'h0, i[0], i[0]});
        end
        $display("Test fan-out done");
        wr(tcr_pkg::OFS_ROUTE_W0, 32'h3);
        wr(tcr_pkg::OFS_PORT_IN_CFG, 32'h3);
        wr(tcr_pkg::OFS_RAD_OUT_INV, 32'h1);
        for (i = 0; i < 4; i++)
        begin
            port_drv <= {4'h0, i[1:0]};
            settle();
            chk({31'h0, rd_o[0]}, {31'h0, i == 3});
        end
        $display("Test AND done");
        wr(tcr_pkg::OFS_ROUTE_SEL, 32'h27);
        wr(tcr_pkg::OFS_ROUTE_W0, 32'h100);
        wr(tcr_pkg::OFS_BUS_IN_INV, 32'h4);
        wr(tcr_pkg::OFS_RAD_OE, 32'h3);
        for (i = 0; i < 2; i++)
        begin
            shared_drv <= {29'h0, i[0], 2'h0};
            settle();
            chk({31'h0, rd_o[1]}, {31'h0, ~i[0]});
        end
        wr(tcr_pkg::OFS_ROUTE_W0, 32'h0);
        wr(tcr_pkg::OFS_ROUTE_W1, 32'h400);
        wr(tcr_pkg::OFS_RAD_IN_INV, 32'h10);
        settle();
        chk({31'h0, rd_o[1]}, 32'h1);
        wr(tcr_pkg::OFS_PORT_IN_CFG, 32'h0);
        port_drv <= 6'h00;
        wr(tcr_pkg::OFS_BUS_OUT_INV, 32'h1);
        settle();
        chk({31'h0, sh_o[0]}, 32'h1);
        $display("Test inversion done");
        wr(tcr_pkg::OFS_ROUTE_SEL, 32'h0);
        wr(tcr_pkg::OFS_ROUTE_W2, 32'h40);
        wr(tcr_pkg::OFS_SW_SHARED_TRIGGER_LINE, 32'h1);
        for (i = 0; i < 4; i++)
        begin
            wr(tcr_pkg::OFS_PORT_OUT_CFG, cfg_tab[i]);
            settle();
            chk({30'h0, port_o[0], port_oe[0]},
                {30'h0, exp_tab[i]});
        end
        $display("Test port output done");
        finish_test();
    end
endmodule
